/* hdl/idc_dma_regs.sv */
// Channel address, count, page and command ports of the DMA block
`timescale 1ns/100ps
module idc_dma_regs (
    input wire logic ref_clk_in,                 // 10 MHz bridge clock
    input wire logic reset_n_in,                 // Processor reset, low
    input wire logic [7:0] io_addr_in,           // I/O port address
    input wire logic io_wr_in,                   // Write strobe, 1 cycle
    input wire logic io_rd_in,                   // Read strobe, 1 cycle
    input wire logic [7:0] io_wdata_in,          // Write data byte
    output logic [7:0] io_rdata_out,             // Read data, next cycle
    input wire logic [7:0] xfer_done_in,         // One transfer finished
    input wire logic [7:0] chan_dec_in,          // 1 = address steps down
    input wire logic [7:0] chan_autoinit_in,     // Autoinitialize enable
    input wire logic [7:0] chan_request_in,      // Pending request levels
    output logic [7:0][23:0] xfer_addr_out,      // 24-bit transfer address
    output logic [7:0] count_expiry_out,         // Expiry pulse per channel
    output logic [7:0] chan_mask_out             // Effective channel masks
);
    import idc_pkg::*;

    typedef struct packed {
        logic [7:0][15:0] base_addr;
        logic [7:0][15:0] cur_addr;
        logic [7:0][15:0] base_cnt;
        logic [7:0][15:0] cur_cnt;
        logic [7:0][7:0] page;
        logic [1:0] ptr;
        logic [7:0] tc;
        logic [7:0] mask;
        logic [7:0] expiry;
        logic [7:0] rdata;
    } idc_state_type;

    idc_state_type st_r;
    idc_state_type st_nxt;

    //--------------------------------------------------------------------
    // Next-state logic
    //--------------------------------------------------------------------
    always_comb begin
        logic [1:0] acc_hit;
        logic [1:0] acc_ptr;
        int k;
        acc_hit = 2'b00;
        acc_ptr = 2'b00;
        k = 0;
        st_nxt = st_r;
        st_nxt.expiry = 8'h00;
        acc_ptr = st_r.ptr;

        // Commands first, so a same-cycle expiry still sets its flags
        for (int g = 0; g < 2; g++) begin
            if (io_wr_in && io_addr_in == IDC_WIPE_PORT[g]) begin
                st_nxt.ptr[g] = 1'b0;
                st_nxt.tc[g*4 +: 4] = 4'h0;
                st_nxt.mask[g*4 +: 4] = IDC_MASK_RESET[g*4 +: 4];
            end
            if (io_wr_in && io_addr_in == IDC_CLR_PTR_PORT[g]) begin
                st_nxt.ptr[g] = 1'b0;
            end
            if (io_wr_in && io_addr_in == IDC_UNMASK_PORT[g]) begin
                st_nxt.mask[g*4 +: 4] = 4'h0;
            end
            if (io_rd_in && io_addr_in == IDC_STATUS_PORT[g]) begin
                // Reading status acknowledges the expiry flags
                st_nxt.tc[g*4 +: 4] = 4'h0;
            end
        end

        // Transfer progress per channel
        for (int c = 0; c < IDC_NCHAN; c++) begin
            if (xfer_done_in[c]) begin
                if (chan_dec_in[c]) begin
                    st_nxt.cur_addr[c] = st_r.cur_addr[c] - 16'h0001;
                end else begin
                    st_nxt.cur_addr[c] = st_r.cur_addr[c] + 16'h0001;
                end
                // Expiry only after the zero count is used: count+1 xfers
                if (st_r.cur_cnt[c] == 16'h0000) begin
                    st_nxt.expiry[c] = 1'b1;
                    st_nxt.tc[c] = 1'b1;
                    if (chan_autoinit_in[c]) begin
                        // Base copies stay as programmed
                        st_nxt.cur_addr[c] = st_r.base_addr[c];
                        st_nxt.cur_cnt[c] = st_r.base_cnt[c];
                    end else begin
                        st_nxt.cur_cnt[c] = IDC_CNT_EXPIRED;
                        st_nxt.mask[c] = 1'b1;
                    end
                end else begin
                    st_nxt.cur_cnt[c] = st_r.cur_cnt[c] - 16'h0001;
                end
            end
        end

        // Host byte accesses to address, count and page ports
        if (io_wr_in || io_rd_in) begin
            st_nxt.rdata = 8'h00;
        end
        for (int c = 0; c < IDC_NCHAN; c++) begin
            k = c / IDC_CHAN_PER_CTRL;
            if (io_addr_in == IDC_ADDR_PORT[c]) begin
                if (io_wr_in) begin
                    acc_hit[k] = 1'b1;
                    if (acc_ptr[k]) begin
                        st_nxt.base_addr[c][15:8] = io_wdata_in;
                        st_nxt.cur_addr[c][15:8] = io_wdata_in;
                    end else begin
                        st_nxt.base_addr[c][7:0] = io_wdata_in;
                        st_nxt.cur_addr[c][7:0] = io_wdata_in;
                    end
                end else if (io_rd_in) begin
                    acc_hit[k] = 1'b1;
                    st_nxt.rdata = acc_ptr[k] ? st_r.cur_addr[c][15:8]
                                              : st_r.cur_addr[c][7:0];
                end
            end
            if (io_addr_in == IDC_CNT_PORT[c]) begin
                if (io_wr_in) begin
                    acc_hit[k] = 1'b1;
                    if (acc_ptr[k]) begin
                        st_nxt.base_cnt[c][15:8] = io_wdata_in;
                        st_nxt.cur_cnt[c][15:8] = io_wdata_in;
                    end else begin
                        st_nxt.base_cnt[c][7:0] = io_wdata_in;
                        st_nxt.cur_cnt[c][7:0] = io_wdata_in;
                    end
                end else if (io_rd_in) begin
                    acc_hit[k] = 1'b1;
                    st_nxt.rdata = acc_ptr[k] ? st_r.cur_cnt[c][15:8]
                                              : st_r.cur_cnt[c][7:0];
                end
            end
            if (IDC_PAGE_VALID[c] && io_addr_in == IDC_PAGE_PORT[c]) begin
                if (io_wr_in) begin
                    st_nxt.page[c] = io_wdata_in;
                end else if (io_rd_in) begin
                    st_nxt.rdata = st_r.page[c];
                end
            end
        end
        for (int g = 0; g < 2; g++) begin
            if (io_rd_in && io_addr_in == IDC_STATUS_PORT[g]) begin
                st_nxt.rdata = {chan_request_in[g*4 +: 4],
                                st_r.tc[g*4 +: 4]};
            end
            if (acc_hit[g]) begin
                st_nxt.ptr[g] = ~st_r.ptr[g];
            end
        end
    end

    //--------------------------------------------------------------------
    // State register
    //--------------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_r <= '0;
            st_r.mask <= IDC_MASK_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    //--------------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------------
    assign io_rdata_out = st_r.rdata;
    assign count_expiry_out = st_r.expiry;
    // Controller 1 cascades through channel 4, so that mask covers it
    assign chan_mask_out = {st_r.mask[7:4],
        st_r.mask[3:0] | {4{st_r.mask[IDC_CASCADE_CHAN]}}};

    genvar gc;
    generate
        for (gc = 0; gc < IDC_NCHAN; gc++) begin : g_addr
            if (gc < IDC_CHAN_PER_CTRL) begin : g_byte
                assign xfer_addr_out[gc] =
                    {st_r.page[gc], st_r.cur_addr[gc]};
            end else begin : g_word
                // Word channels: address shifted left, page bit 0 unused
                assign xfer_addr_out[gc] = {st_r.page[gc][7:1],
                    st_r.cur_addr[gc], 1'b0};
            end
        end
    endgenerate

    //--------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);

    property p_status_tc;
        logic [3:0] t;
        (io_rd_in && io_addr_in == IDC_STATUS_PORT[0]
            && xfer_done_in[3:0] == 4'h0, t = st_r.tc[3:0])
            |=> io_rdata_out[3:0] == t && st_r.tc[3:0] == 4'h0;
    endproperty
    a_status_tc: assert property (p_status_tc)
        else $error("status low nibble does not show expiry flags");

    property p_addr_step;
        xfer_done_in[1] && !chan_dec_in[1] && st_r.cur_cnt[1] != 16'h0000
            && !io_wr_in
            |=> st_r.cur_addr[1] == $past(st_r.cur_addr[1]) + 16'h0001;
    endproperty
    a_addr_step: assert property (p_addr_step)
        else $error("address did not step up after transfer");

    property p_expiry;
        xfer_done_in[1] && st_r.cur_cnt[1] == 16'h0000
            |=> count_expiry_out[1] ##1 !count_expiry_out[1];
    endproperty
    a_expiry: assert property (p_expiry)
        else $error("expiry pulse missing or too long");

    property p_hold_ones;
        xfer_done_in[1] && !chan_autoinit_in[1] && !io_wr_in
            && st_r.cur_cnt[1] == 16'h0000
            |=> st_r.cur_cnt[1] == IDC_CNT_EXPIRED && st_r.mask[1];
    endproperty
    a_hold_ones: assert property (p_hold_ones)
        else $error("count not all ones or mask clear after expiry");

    property p_reload;
        xfer_done_in[5] && chan_autoinit_in[5] && !io_wr_in
            && st_r.cur_cnt[5] == 16'h0000
            |=> st_r.cur_cnt[5] == st_r.base_cnt[5]
                && st_r.cur_addr[5] == st_r.base_addr[5];
    endproperty
    a_reload: assert property (p_reload)
        else $error("autoinitialize reload did not restore base");

    property p_clr_ptr;
        io_wr_in && io_addr_in == IDC_CLR_PTR_PORT[1] |=> !st_r.ptr[1];
    endproperty
    a_clr_ptr: assert property (p_clr_ptr)
        else $error("byte pointer not cleared");

    property p_unmask;
        io_wr_in && io_addr_in == IDC_UNMASK_PORT[0] && xfer_done_in[3:0]
            == 4'h0 |=> st_r.mask[3:0] == 4'h0;
    endproperty
    a_unmask: assert property (p_unmask)
        else $error("clear mask left a channel masked");

    property p_cascade;
        st_r.mask[IDC_CASCADE_CHAN] |-> chan_mask_out[3:0] == 4'hF;
    endproperty
    a_cascade: assert property (p_cascade)
        else $error("channel 4 mask did not cover controller 1");

    property p_ptr_toggle;
        io_wr_in && io_addr_in == IDC_ADDR_PORT[0]
            |=> st_r.ptr[0] != $past(st_r.ptr[0]);
    endproperty
    a_ptr_toggle: assert property (p_ptr_toggle)
        else $error("byte pointer did not toggle on access");

    property p_two_bytes;
        !st_r.ptr[0] && io_wr_in && io_addr_in == IDC_CNT_PORT[0]
            ##2 io_wr_in && io_addr_in == IDC_CNT_PORT[0]
            && xfer_done_in[0] == 1'b0
            |=> st_r.base_cnt[0] ==
                {$past(io_wdata_in), $past(io_wdata_in, 3)};
    endproperty
    a_two_bytes: assert property (p_two_bytes)
        else $error("two byte writes did not assemble the count");

    property p_wipe;
        io_wr_in && io_addr_in == IDC_WIPE_PORT[1]
            && xfer_done_in[7:4] == 4'h0
            |=> st_r.mask[7:4] == 4'hF && st_r.tc[7:4] == 4'h0;
    endproperty
    a_wipe: assert property (p_wipe)
        else $error("master clear did not reset controller 2");

    //--------------------------------------------------------------------
    // Further checks on transfer and host paths
    //--------------------------------------------------------------------
    property p_addr_down;
        xfer_done_in[5] && chan_dec_in[5] && st_r.cur_cnt[5] != 16'h0000
            && !io_wr_in
            |=> st_r.cur_addr[5] == $past(st_r.cur_addr[5]) - 16'h0001;
    endproperty
    a_addr_down: assert property (p_addr_down)
        else $error("address did not step down after transfer");

    property p_cnt_step;
        xfer_done_in[1] && st_r.cur_cnt[1] != 16'h0000 && !io_wr_in
            |=> st_r.cur_cnt[1] == $past(st_r.cur_cnt[1]) - 16'h0001
                && !count_expiry_out[1];
    endproperty
    a_cnt_step: assert property (p_cnt_step)
        else $error("count did not step or expired early");

    property p_no_stray_expiry;
        xfer_done_in == 8'h00 |=> count_expiry_out == 8'h00;
    endproperty
    a_no_stray_expiry: assert property (p_no_stray_expiry)
        else $error("expiry without a transfer");

    property p_base_keep;
        !io_wr_in |=> st_r.base_addr == $past(st_r.base_addr)
            && st_r.base_cnt == $past(st_r.base_cnt);
    endproperty
    a_base_keep: assert property (p_base_keep)
        else $error("base copy changed without a host write");

    property p_page_keep;
        !io_wr_in |=> st_r.page == $past(st_r.page);
    endproperty
    a_page_keep: assert property (p_page_keep)
        else $error("page changed without a host write");

    property p_page_wr;
        io_wr_in && io_addr_in == IDC_PAGE_PORT[1]
            |=> st_r.page[1] == $past(io_wdata_in);
    endproperty
    a_page_wr: assert property (p_page_wr)
        else $error("page write did not land");

    property p_rd_low;
        io_rd_in && io_addr_in == IDC_ADDR_PORT[1] && !st_r.ptr[0]
            |=> io_rdata_out == $past(st_r.cur_addr[1][7:0]);
    endproperty
    a_rd_low: assert property (p_rd_low)
        else $error("low address byte read wrong");

    property p_rd_high;
        io_rd_in && io_addr_in == IDC_CNT_PORT[1] && st_r.ptr[0]
            |=> io_rdata_out == $past(st_r.cur_cnt[1][15:8]);
    endproperty
    a_rd_high: assert property (p_rd_high)
        else $error("high count byte read wrong");

    property p_wr_both;
        io_wr_in && io_addr_in == IDC_ADDR_PORT[2] && !st_r.ptr[0]
            |=> st_r.base_addr[2][7:0] == $past(io_wdata_in)
                && st_r.cur_addr[2][7:0] == $past(io_wdata_in);
    endproperty
    a_wr_both: assert property (p_wr_both)
        else $error("address write missed base or current copy");

    property p_auto_unmasked;
        xfer_done_in[5] && chan_autoinit_in[5] && !io_wr_in
            && st_r.cur_cnt[5] == 16'h0000
            |=> st_r.mask[5] == $past(st_r.mask[5]);
    endproperty
    a_auto_unmasked: assert property (p_auto_unmasked)
        else $error("autoinitialize channel masked at expiry");

    property p_tc_set;
        count_expiry_out[1] |-> st_r.tc[1];
    endproperty
    a_tc_set: assert property (p_tc_set)
        else $error("expiry flag not set with pulse");

    property p_wipe_ptr;
        io_wr_in && io_addr_in == IDC_WIPE_PORT[0] |=> !st_r.ptr[0];
    endproperty
    a_wipe_ptr: assert property (p_wipe_ptr)
        else $error("master clear left byte pointer set");

    property p_clr_ptr0;
        io_wr_in && io_addr_in == IDC_CLR_PTR_PORT[0] |=> !st_r.ptr[0];
    endproperty
    a_clr_ptr0: assert property (p_clr_ptr0)
        else $error("byte pointer of controller 1 not cleared");

    property p_unmask2;
        io_wr_in && io_addr_in == IDC_UNMASK_PORT[1]
            && xfer_done_in[7:4] == 4'h0 |=> st_r.mask[7:4] == 4'h0;
    endproperty
    a_unmask2: assert property (p_unmask2)
        else $error("clear mask left a controller 2 channel masked");

    property p_status_hi;
        io_rd_in && io_addr_in == IDC_STATUS_PORT[1]
            && xfer_done_in[7:4] == 4'h0
            |=> io_rdata_out == {$past(chan_request_in[7:4]),
                $past(st_r.tc[7:4])} && st_r.tc[7:4] == 4'h0;
    endproperty
    a_status_hi: assert property (p_status_hi)
        else $error("controller 2 status read wrong");

    property p_rdata_hold;
        !io_wr_in && !io_rd_in |=> $stable(io_rdata_out);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data changed without a strobe");
endmodule

/* hdl/idc_pkg.sv */
// Constants and port map of the eight-channel DMA register block
//------------------------------------------------------------------------
// Overview of operation
// - Status low four bits show which channels of the controller hit count expiry.
// - Each transfer steps the current address up or down by one, except an autoinitialize expiry, which reloads the base address.
// - Base copies of address and count keep the programmed start value.
// - Autoinitialize reload happens only at count expiry of that channel.
// - Sixteen-bit registers go through one byte port, two accesses via byte pointer.
// - Sixteen-bit address forms the low bits, page byte the top of 24 bits.
// - Each page register is eight bits, read and write; address bits 23:16, or bits 7:1 as 23:17 on word channels.
// - A channel performs one transfer more than its programmed count.
// - Count expiry rises on a transfer made while the current count is zero.
// - Without autoinitialize the count is loaded with all ones at expiry; later transfers still count it down.
// - Channels 0-3 count bytes; channels 4-7 count words with shifted address.
// - Clear pointer write, reset or master clear return pointer to low byte.
// - Master clear write sets the masks and clears the expiry flags and byte pointer of its controller.
// - Clear mask write unmasks all four channels of that controller.
// - Count ports: address plus one on first, plus two on second.
// - Count expiry sets the channel mask unless autoinitialize is on.
// - Masking channel 4 also masks channels 0 to 3.
//------------------------------------------------------------------------
package idc_pkg;
    localparam int IDC_NCHAN = 8;
    localparam int IDC_CHAN_PER_CTRL = 4;
    // Port tables, one byte per channel, channel 7 in the top byte
    localparam logic [7:0][7:0] IDC_ADDR_PORT =
        {8'hCC, 8'hC8, 8'hC4, 8'hC0, 8'h06, 8'h04, 8'h02, 8'h00};
    localparam logic [7:0][7:0] IDC_CNT_PORT =
        {8'hCE, 8'hCA, 8'hC6, 8'hC2, 8'h07, 8'h05, 8'h03, 8'h01};
    localparam logic [7:0][7:0] IDC_PAGE_PORT =
        {8'h00, 8'h89, 8'h8B, 8'h00, 8'h82, 8'h81, 8'h83, 8'h87};
    // Channels 4 and 7 have no page port here
    localparam logic [7:0] IDC_PAGE_VALID = 8'h6F;
    // Per-controller command and status ports, controller 2 in top byte
    localparam logic [1:0][7:0] IDC_STATUS_PORT = {8'hD0, 8'h08};
    localparam logic [1:0][7:0] IDC_CLR_PTR_PORT = {8'hD8, 8'h0C};
    localparam logic [1:0][7:0] IDC_WIPE_PORT = {8'hDA, 8'h0D};
    localparam logic [1:0][7:0] IDC_UNMASK_PORT = {8'hDC, 8'h0E};
    localparam logic [7:0] IDC_MASK_RESET = 8'hFF;
    localparam logic [15:0] IDC_CNT_EXPIRED = 16'hFFFF;
    localparam int IDC_CASCADE_CHAN = 4;
endpackage

/* dv/idc_host_model.sv */
// Host processor model issuing byte-wide I/O port cycles
`timescale 1ns/100ps
module idc_host_model (
    input wire logic clk_in,           // Bus clock
    input wire logic [7:0] rdata_in,   // Read data from the block
    output logic [7:0] addr_out,       // I/O port address
    output logic wr_out,               // Write strobe
    output logic rd_out,               // Read strobe
    output logic [7:0] wdata_out       // Write data byte
);
    initial begin
        addr_out = 8'hFF;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = 8'h00;
    end

    //--------------------------------------------------------------------
    // Single byte cycles
    //--------------------------------------------------------------------
    // Released lines carry the inverse so stale values cannot pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_in);
        wr_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        @(posedge clk_in);
        d = rdata_in;
    endtask

    //--------------------------------------------------------------------
    // Sixteen-bit values, pointer cleared first
    //--------------------------------------------------------------------
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a >= 8'hC0 ? 8'hD8 : 8'h0C, 8'h00);
        wr(a, v[7:0]);
        wr(a, v[15:8]);
    endtask

    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        wr(a >= 8'hC0 ? 8'hD8 : 8'h0C, 8'h00);
        rd(a, v[7:0]);
        rd(a, v[15:8]);
    endtask
endmodule

/* dv/isa_dma_channel_registers_tb.sv */
// Self-checking bench for the DMA channel register block
`timescale 1ns/100ps
module isa_dma_channel_registers_tb;
    import idc_pkg::*;
    logic ref_clk_in;
    logic reset_n_in;
    logic [7:0] io_addr, io_wdata, io_rdata;
    logic io_wr, io_rd;
    logic [7:0] done, dec, autoinit, request;
    logic [7:0][23:0] xfer_addr;
    logic [7:0] expiry, mask;
    int fails = 0;
    int checked = 0;

    idc_dma_regs DUT (
        .ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
        .io_addr_in(io_addr), .io_wr_in(io_wr), .io_rd_in(io_rd),
        .io_wdata_in(io_wdata), .io_rdata_out(io_rdata),
        .xfer_done_in(done), .chan_dec_in(dec),
        .chan_autoinit_in(autoinit), .chan_request_in(request),
        .xfer_addr_out(xfer_addr), .count_expiry_out(expiry),
        .chan_mask_out(mask));

    idc_host_model u_host (
        .clk_in(ref_clk_in), .rdata_in(io_rdata), .addr_out(io_addr),
        .wr_out(io_wr), .rd_out(io_rd), .wdata_out(io_wdata));

    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end

    //--------------------------------------------------------------------
    // Helpers
    //--------------------------------------------------------------------
    task automatic chk(input string what, input logic [23:0] exp,
                       input logic [23:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One transfer; reports the expiry bit in the following cycle
    task automatic pulse(input int c, output logic hit);
        @(posedge ref_clk_in);
        done <= 8'h01 << c;
        @(posedge ref_clk_in);
        done <= 8'h00;
        #1 hit = expiry[c];
    endtask

    task automatic tally_and_finish;
        if (fails == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge ref_clk_in);
        fails++;
        tally_and_finish;
    end

    //--------------------------------------------------------------------
    // Test sequence
    //--------------------------------------------------------------------
    initial begin : main
        logic [15:0] a, n, v;
        logic [7:0] p, b;
        logic hit;
        reset_n_in = 1'b0;
        done = 8'h00;
        dec = 8'h00;
        autoinit = 8'h00;
        request = 8'h00;
        repeat (3) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        @(posedge ref_clk_in);
        #1 chk("mask", 24'hFF, mask);
        chk("expiry", 24'h00, expiry);
        // Every channel: write, read back, transfer address
        for (int c = 0; c < IDC_NCHAN; c++) begin
            u_host.wr16(IDC_ADDR_PORT[c], 16'h1357 + 16'(c) * 16'h1111);
            u_host.wr16(IDC_CNT_PORT[c], 16'h0F00 + 16'(c));
            if (IDC_PAGE_VALID[c])
                u_host.wr(IDC_PAGE_PORT[c], 8'h20 + 8'(c) * 8'h11);
        end
        for (int c = 0; c < IDC_NCHAN; c++) begin
            a = 16'h1357 + 16'(c) * 16'h1111;
            p = IDC_PAGE_VALID[c] ? 8'h20 + 8'(c) * 8'h11 : 8'h00;
            u_host.rd16(IDC_ADDR_PORT[c], v);
            chk("address", a, v);
            u_host.rd16(IDC_CNT_PORT[c], v);
            chk("count", 16'h0F00 + 16'(c), v);
            if (IDC_PAGE_VALID[c]) begin
                u_host.rd(IDC_PAGE_PORT[c], b);
                chk("page", p, b);
            end
            chk("xfer address", c < 4 ? {p, a} : {p[7:1], a, 1'b0},
                xfer_addr[c]);
        end
        u_host.rd(8'h40, b);
        chk("unmapped", 24'h00, b);
        // Unmask commands and cascade
        u_host.wr(8'h0E, 8'h3C);
        #1 chk("mask", 24'hFF, mask);
        u_host.wr(8'hDC, 8'hC3);
        #1 chk("mask", 24'h00, mask);
        // Byte pointer clear by command and by master clear
        u_host.wr(8'h0C, 8'h00);
        u_host.wr(IDC_ADDR_PORT[1], 8'hEE);
        u_host.wr(8'h0C, 8'h5A);
        u_host.rd(IDC_ADDR_PORT[1], b);
        chk("low byte", 24'hEE, b);
        u_host.wr(8'h0D, 8'hA5);
        #1 chk("mask", 24'h0F, mask);
        u_host.rd(IDC_ADDR_PORT[1], b);
        chk("low byte", 24'hEE, b);
        u_host.wr(8'h0E, 8'h00);
        // Channel 1: count 2 gives three transfers, no reload
        @(posedge ref_clk_in);
        request <= 8'h22;
        u_host.wr16(IDC_ADDR_PORT[1], 16'h1000);
        u_host.wr16(IDC_CNT_PORT[1], 16'h0002);
        for (int k = 0; k < 3; k++) begin
            pulse(1, hit);
            chk("expiry", k == 2, hit);
        end
        chk("xfer address", {8'h31, 16'h1003}, xfer_addr[1]);
        chk("mask", 24'h02, mask);
        u_host.rd16(IDC_CNT_PORT[1], v);
        chk("count", 16'hFFFF, v);
        u_host.rd(8'h08, b);
        chk("status", 24'h22, b);
        u_host.rd(8'h08, b);
        chk("status", 24'h20, b);
        // Channel 5: word channel, stepping down, autoinitialize
        @(posedge ref_clk_in);
        dec <= 8'h20;
        autoinit <= 8'h20;
        u_host.wr16(IDC_ADDR_PORT[5], 16'h0100);
        u_host.wr16(IDC_CNT_PORT[5], 16'h0001);
        pulse(5, hit);
        chk("expiry", 24'h0, hit);
        chk("xfer address", {7'h3A, 16'h00FF, 1'b0}, xfer_addr[5]);
        pulse(5, hit);
        chk("expiry", 24'h1, hit);
        chk("xfer address", {7'h3A, 16'h0100, 1'b0}, xfer_addr[5]);
        chk("mask", 24'h02, mask);
        u_host.rd16(IDC_CNT_PORT[5], v);
        chk("count", 16'h0001, v);
        u_host.rd(8'hD0, b);
        chk("status", 24'h22, b);
        u_host.wr(8'hDA, 8'h00);
        #1 chk("mask", 24'hFF, mask);
        tally_and_finish;
    end
endmodule
